// file: hw/rx_los_cdr_pkg.sv
// Shared constants for the receive loss-of-signal and recovery-loop control block
package rx_los_cdr_pkg;

    // ========================================================================
    // Loss-of-signal detection
    // ========================================================================
    localparam int unsigned LOS_DECLARE_BITS      = 128;
    localparam int unsigned LOS_WINDOW_BITS       = 128;
    localparam int unsigned LOS_CLEAR_TRANSITIONS = 16;
    localparam int unsigned LOS_COUNT_W           = 8;
    localparam logic [LOS_COUNT_W-1:0] LOS_RUN_LIMIT   = LOS_COUNT_W'(LOS_DECLARE_BITS);
    localparam logic [LOS_COUNT_W-1:0] LOS_CLEAR_LIMIT = LOS_COUNT_W'(LOS_CLEAR_TRANSITIONS);
    localparam logic [LOS_COUNT_W-1:0] LOS_COUNT_ZERO  = 8'h00;
    localparam logic [LOS_COUNT_W-1:0] LOS_COUNT_ONE   = 8'h01;

    // ========================================================================
    // Deserializer and input sampling
    // ========================================================================
    localparam int unsigned BYTE_BITS  = 8;
    localparam int unsigned BIT_CNT_W  = 3;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST = 3'h7;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 3'h0;
    localparam logic [BYTE_BITS-1:0] MUTE_BYTE    = 8'h00;
    localparam int unsigned SYNC_W     = 9;

    // Positions in the synchronised pin vector
    localparam int unsigned SY_SERIAL   = 0;
    localparam int unsigned SY_EXTCLK   = 1;
    localparam int unsigned SY_EXTLOS_N = 2;
    localparam int unsigned SY_BYPASS   = 3;
    localparam int unsigned SY_LOSDIS   = 4;
    localparam int unsigned SY_RATE     = 5;
    localparam int unsigned SY_FREQSEL  = 6;
    localparam int unsigned SY_REFSEL   = 7;
    localparam int unsigned SY_INRANGE  = 8;

    // ========================================================================
    // Recovery loop states
    // ========================================================================
    typedef enum logic [0:0] {
        LOOP_LOCK_REF,
        LOOP_LOCK_DATA
    } loop_state_t;

endpackage

// file: hw/los_detector.sv
// Transition-based internal loss-of-signal detector on the serial bit stream
`timescale 1ns/100ps
module los_detector
    import rx_los_cdr_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic bit_valid_i,
    input  wire logic bit_i,
    input  wire logic disable_i,
    output logic      los_o
);

    logic                       last_bit_reg;
    logic [LOS_WINDOW_BITS-1:0] history_reg;
    logic [LOS_COUNT_W-1:0]     window_count_reg;
    logic [LOS_COUNT_W-1:0]     run_count_reg;
    logic [LOS_COUNT_W-1:0]     window_count_next;
    logic [LOS_COUNT_W-1:0]     run_count_next;
    logic                       transition;
    logic                       oldest;

    assign transition = bit_i ^ last_bit_reg;
    assign oldest     = history_reg[LOS_WINDOW_BITS-1];

    always_comb begin
        // Sliding window count: add the newest transition, drop the oldest
        window_count_next = window_count_reg + LOS_COUNT_W'(transition) - LOS_COUNT_W'(oldest);
        if (transition) begin
            run_count_next = LOS_COUNT_ZERO;
        end else if (run_count_reg > LOS_RUN_LIMIT) begin
            run_count_next = run_count_reg; // Saturate once beyond the limit
        end else begin
            run_count_next = run_count_reg + LOS_COUNT_ONE;
        end
    end

    // ========================================================================
    // Counters and history, advanced once per received bit
    // ========================================================================
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            last_bit_reg     <= 1'b0;
            history_reg      <= '0;
            window_count_reg <= LOS_COUNT_ZERO;
            run_count_reg    <= LOS_COUNT_ZERO;
        end else if (bit_valid_i) begin
            last_bit_reg     <= bit_i;
            history_reg      <= {history_reg[LOS_WINDOW_BITS-2:0], transition};
            window_count_reg <= window_count_next;
            run_count_reg    <= run_count_next;
        end
    end

    // ========================================================================
    // Declare and clear
    // ========================================================================
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            los_o <= 1'b0;
        end else if (disable_i) begin
            los_o <= 1'b0;
        end else if (bit_valid_i) begin
            if (!los_o && run_count_next > LOS_RUN_LIMIT) begin
                los_o <= 1'b1;
            end else if (los_o && window_count_next >= LOS_CLEAR_LIMIT) begin
                los_o <= 1'b0;
            end
        end
    end

endmodule // los_detector

// file: hw/rx_los_cdr_lock_control.sv
// Receive loss-of-signal, data mute and clock-recovery loop steering
//
// What this block does
// - Declare internal loss when no transition is seen for over 128 bits.
// - Clear internal loss after 16 transitions within a 128-bit sliding window.
// - Internal-detection disable high holds internal loss low; the detector's run and window counters keep counting.
// - External loss input is active low; low forces loss of signal.
// - Loss of signal is internal loss OR external loss asserted.
// - While loss is declared, all eight parallel output bits are forced to 0.
// - After start-up, lock to local reference first, then attempt data lock.
// - Recovered clock out of 500 ppm range returns the loop to reference lock.
// - During loss of lock or signal, receive clock stays reference-derived.
// - Return to data lock only if no external loss, no internal loss, in range.
// - Reference select picks main (77.76/19.44 by frequency select) or auxiliary 77.76.
// - Recovery bypass samples serial input on external recovered clock rising edge.
// - Line-rate select low means 155.52 Mbps, high means 622.08 Mbps.
`timescale 1ns/100ps
module rx_los_cdr_lock_control
    import rx_los_cdr_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 reset_i,
    input  wire logic                 rx_serial_in_i,
    input  wire logic                 ext_recovered_clock_i,
    input  wire logic                 external_loss_n_i,
    input  wire logic                 recovery_bypass_i,
    input  wire logic                 internal_los_disable_i,
    input  wire logic                 line_rate_select_i,
    input  wire logic                 ref_freq_select_i,
    input  wire logic                 recovery_ref_select_i,
    input  wire logic                 freq_in_range_i,
    input  wire logic                 ref_lock_done_i,
    output logic [BYTE_BITS-1:0]      rx_parallel_out_o,
    output logic                      byte_strobe_o,
    output logic                      los_o,
    output logic                      internal_los_o,
    output logic                      data_lock_o,
    output logic                      rx_clock_from_ref_o,
    output logic                      use_aux_ref_o,
    output logic                      main_ref_is_19m44_o,
    output logic                      rate_622_o
);

    // ========================================================================
    // Pin synchronisers
    // ========================================================================
    // Three stages; a change is accepted once stages two and three agree.
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [SYNC_W-1:0] sync3_reg;
    logic [SYNC_W-1:0] pins_reg;
    logic [SYNC_W-1:0] raw_pins;
    logic [SYNC_W-1:0] settled;

    // External loss idles inactive (high) in every stage so reset does not fake a loss
    localparam logic [SYNC_W-1:0] PINS_IDLE  = SYNC_W'(1) << SY_EXTLOS_N;
    localparam logic [SYNC_W-1:0] UNFILTERED = SYNC_W'(1) << SY_SERIAL;

    assign raw_pins = {freq_in_range_i, recovery_ref_select_i, ref_freq_select_i, line_rate_select_i,
                       internal_los_disable_i, recovery_bypass_i, external_loss_n_i,
                       ext_recovered_clock_i, rx_serial_in_i};
    // Serial data already runs at one bit per clock; the agreement filter would
    // swallow single-bit runs, so it only takes the delay to stay aligned
    // with the sampled external clock
    assign settled  = ~(sync2_reg ^ sync3_reg) | UNFILTERED;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_reg <= PINS_IDLE;
            sync2_reg <= PINS_IDLE;
            sync3_reg <= PINS_IDLE;
            pins_reg  <= PINS_IDLE;
        end else begin
            sync1_reg <= raw_pins;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pins_reg  <= (sync3_reg & settled) | (pins_reg & ~settled);
        end
    end

    // ========================================================================
    // Bit sampling: bit clock, or external recovered clock in bypass
    // ========================================================================
    logic ext_clk_last_reg;
    logic bit_valid_reg;
    logic bit_reg;
    logic ext_clk_rise;

    assign ext_clk_rise = pins_reg[SY_EXTCLK] & ~ext_clk_last_reg;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ext_clk_last_reg <= 1'b0;
            bit_valid_reg    <= 1'b0;
            bit_reg          <= 1'b0;
        end else begin
            ext_clk_last_reg <= pins_reg[SY_EXTCLK];
            // Bypass: one bit per rising edge of the external recovered clock
            bit_valid_reg    <= pins_reg[SY_BYPASS] ? ext_clk_rise : 1'b1;
            bit_reg          <= pins_reg[SY_SERIAL];
        end
    end

    // ========================================================================
    // Loss of signal
    // ========================================================================
    logic internal_los;
    logic external_los;
    logic los_any;

    los_detector u_los_detector (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .bit_valid_i (bit_valid_reg),
        .bit_i       (bit_reg),
        .disable_i   (pins_reg[SY_LOSDIS]),
        .los_o       (internal_los)
    );

    assign external_los = ~pins_reg[SY_EXTLOS_N];
    assign los_any      = internal_los | external_los;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            los_o          <= 1'b0;
            internal_los_o <= 1'b0;
        end else begin
            los_o          <= los_any;
            internal_los_o <= internal_los;
        end
    end

    // ========================================================================
    // Deserializer with mute
    // ========================================================================
    logic [BYTE_BITS-1:0] shift_reg;
    logic [BIT_CNT_W-1:0] bit_cnt_reg;
    logic [BYTE_BITS-1:0] shift_next;

    assign shift_next = {shift_reg[BYTE_BITS-2:0], bit_reg};

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            shift_reg   <= MUTE_BYTE;
            bit_cnt_reg <= BIT_CNT_ZERO;
        end else if (bit_valid_reg) begin
            shift_reg   <= shift_next;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_parallel_out_o <= MUTE_BYTE;
            byte_strobe_o     <= 1'b0;
        end else begin
            byte_strobe_o <= bit_valid_reg && bit_cnt_reg == BIT_CNT_LAST;
            // Mute is checked every cycle so a held byte cannot leak through
            if (los_any) begin
                rx_parallel_out_o <= MUTE_BYTE;
            end else if (bit_valid_reg && bit_cnt_reg == BIT_CNT_LAST) begin
                rx_parallel_out_o <= shift_next;
            end
        end
    end

    // ========================================================================
    // Recovery loop steering
    // ========================================================================
    loop_state_t loop_state_reg;
    logic        in_range;

    assign in_range = pins_reg[SY_INRANGE];

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            loop_state_reg <= LOOP_LOCK_REF;
        end else begin
            unique case (loop_state_reg)
                LOOP_LOCK_REF: begin
                    // Reference lock must be achieved before trying the data
                    if (ref_lock_done_i && in_range && !external_los && !internal_los) begin
                        loop_state_reg <= LOOP_LOCK_DATA;
                    end
                end
                LOOP_LOCK_DATA: begin
                    if (!in_range || los_any) begin
                        loop_state_reg <= LOOP_LOCK_REF;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            data_lock_o         <= 1'b0;
            rx_clock_from_ref_o <= 1'b1;
        end else begin
            data_lock_o         <= loop_state_reg == LOOP_LOCK_DATA;
            // Framer clock never stops; it falls back to the reference
            rx_clock_from_ref_o <= loop_state_reg != LOOP_LOCK_DATA || los_any;
        end
    end

    // ========================================================================
    // Reference and rate selection
    // ========================================================================
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            use_aux_ref_o       <= 1'b0;
            main_ref_is_19m44_o <= 1'b0;
            rate_622_o          <= 1'b0;
        end else begin
            use_aux_ref_o       <= pins_reg[SY_REFSEL];
            // Frequency select is ignored while the auxiliary reference is used
            main_ref_is_19m44_o <= ~pins_reg[SY_REFSEL] & pins_reg[SY_FREQSEL];
            rate_622_o          <= pins_reg[SY_RATE];
        end
    end

endmodule // rx_los_cdr_lock_control

// file: tb/optical_line_model.sv
// Far-side model: optical module serial line, recovered clock and signal-detect output
`timescale 1ns/100ps
module optical_line_model #(
    parameter logic [7:0] PATTERN = 8'hA5
) (
    input  wire logic       clk_i,
    input  wire logic       quiet_i,
    input  wire logic [3:0] gap_i,
    input  wire logic       ext_clock_i,
    input  wire logic       no_light_i,
    output logic            serial_o,
    output logic            ext_clock_o,
    output logic            loss_n_o
);
    logic [2:0] div_reg = 3'h0;
    logic [3:0] gap_reg = 4'h0;
    logic [2:0] bit_reg = 3'h7;
    logic       tick;
    logic       serial_reg = 1'b0;
    assign serial_o = serial_reg;
    // ========================================================================
    // Line and recovered clock
    // ========================================================================
    // In bypass the line moves with the falling half of the recovered clock,
    // so the data is settled around every rising edge
    assign ext_clock_o = ext_clock_i & div_reg[2];
    assign tick        = !ext_clock_i || (div_reg == 3'h7);
    assign loss_n_o    = !no_light_i;
    always_ff @(posedge clk_i) begin
        div_reg <= div_reg + 3'h1;
        if (tick && !quiet_i && gap_i != 4'h0) begin
            gap_reg <= (gap_reg + 4'h1 >= gap_i) ? 4'h0 : gap_reg + 4'h1;
            serial_reg <= (gap_reg + 4'h1 >= gap_i) ? !serial_reg : serial_reg;
        end else if (tick && !quiet_i) begin
            serial_reg <= PATTERN[bit_reg];
            bit_reg <= bit_reg - 3'h1;
        end
    end
endmodule // optical_line_model

// file: tb/rx_los_cdr_asserts.sv
// Checker for loss-of-signal, mute and loop steering at the block ports
`timescale 1ns/100ps
module rx_los_cdr_asserts
    import rx_los_cdr_pkg::*;
(
    input wire logic                 clk_i,
    input wire logic                 reset_i,
    input wire logic                 rx_serial_in_i,
    input wire logic                 external_loss_n_i,
    input wire logic                 internal_los_disable_i,
    input wire logic                 line_rate_select_i,
    input wire logic                 ref_freq_select_i,
    input wire logic                 recovery_ref_select_i,
    input wire logic                 freq_in_range_i,
    input wire logic                 ref_lock_done_i,
    input wire logic [BYTE_BITS-1:0] rx_parallel_out_o,
    input wire logic                 byte_strobe_o,
    input wire logic                 los_o,
    input wire logic                 internal_los_o,
    input wire logic                 data_lock_o,
    input wire logic                 rx_clock_from_ref_o,
    input wire logic                 use_aux_ref_o,
    input wire logic                 main_ref_is_19m44_o,
    input wire logic                 rate_622_o
);
    // ========================================================================
    // Run length of the line as seen at the pin, saturating
    // ========================================================================
    logic [7:0] run_reg;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            run_reg <= 8'h00;
        end else if (!$stable(rx_serial_in_i)) begin
            run_reg <= 8'h00;
        end else if (run_reg != 8'hFF) begin
            run_reg <= run_reg + 8'h01;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // ========================================================================
    // Assertions
    // ========================================================================
    a_mute_on_loss: assert property (los_o && $past(los_o) |-> rx_parallel_out_o == MUTE_BYTE)
        else $error("parallel output not muted during loss");
    a_ext_forces_loss: assert property (!external_loss_n_i [*8] |-> los_o)
        else $error("external loss low did not raise loss");
    a_disable_quiet: assert property (internal_los_disable_i [*8] |-> !internal_los_o)
        else $error("internal loss raised while detector disabled");
    a_declare_run: assert property (run_reg == 8'h91 && !internal_los_disable_i && !$past(internal_los_disable_i, 8)
        |-> internal_los_o)
        else $error("long quiet run not declared");
    a_no_early: assert property ($rose(internal_los_o) |-> run_reg >= 8'h80)
        else $error("loss declared before the run was long enough");
    a_lock_clean: assert property ($rose(data_lock_o) |-> $past(ref_lock_done_i) && !los_o)
        else $error("data lock taken without reference lock or with loss");
    a_loss_drops_lock: assert property (los_o [*3] |-> !data_lock_o)
        else $error("data lock kept during loss");
    a_range_drops_lock: assert property (!freq_in_range_i [*8] |-> !data_lock_o)
        else $error("data lock kept out of range");
    a_ref_clock_held: assert property (!data_lock_o && !$past(data_lock_o) |-> rx_clock_from_ref_o)
        else $error("receive clock not reference derived without lock");
    a_aux_select: assert property ($stable(recovery_ref_select_i) [*6] |-> use_aux_ref_o == recovery_ref_select_i)
        else $error("auxiliary reference output wrong");
    a_main_freq: assert property ((!recovery_ref_select_i && ref_freq_select_i) [*6] |-> main_ref_is_19m44_o)
        else $error("main reference frequency output wrong");
    a_rate_select: assert property ($stable(line_rate_select_i) [*6] |-> rate_622_o == line_rate_select_i)
        else $error("line rate output wrong");
    a_byte_spacing: assert property (byte_strobe_o |=> !byte_strobe_o [*7])
        else $error("byte strobes closer than eight bits");
    c_declare: cover property ($rose(internal_los_o));
    c_clear: cover property ($fell(internal_los_o));
    c_lock: cover property ($rose(data_lock_o));
    c_ext_loss: cover property ($fell(external_loss_n_i));
endmodule // rx_los_cdr_asserts
bind rx_los_cdr_lock_control rx_los_cdr_asserts rx_los_cdr_asserts_inst (
    .clk_i(clk_i), .reset_i(reset_i), .rx_serial_in_i(rx_serial_in_i), .external_loss_n_i(external_loss_n_i),
    .internal_los_disable_i(internal_los_disable_i), .line_rate_select_i(line_rate_select_i),
    .ref_freq_select_i(ref_freq_select_i), .recovery_ref_select_i(recovery_ref_select_i),
    .freq_in_range_i(freq_in_range_i), .ref_lock_done_i(ref_lock_done_i), .rx_parallel_out_o(rx_parallel_out_o),
    .byte_strobe_o(byte_strobe_o), .los_o(los_o), .internal_los_o(internal_los_o), .data_lock_o(data_lock_o),
    .rx_clock_from_ref_o(rx_clock_from_ref_o), .use_aux_ref_o(use_aux_ref_o),
    .main_ref_is_19m44_o(main_ref_is_19m44_o), .rate_622_o(rate_622_o)
);

// file: tb/testbench.sv
// Self-checking bench for receive loss-of-signal, mute and loop steering
`timescale 1ns/100ps
module testbench;
    import rx_los_cdr_pkg::*;
    logic                 clk_i = 1'b0;
    logic                 reset_i = 1'b1;
    logic                 rx_serial_in_i, ext_recovered_clock_i, external_loss_n_i;
    logic                 recovery_bypass_i = 1'b0;
    logic                 internal_los_disable_i = 1'b0;
    logic [2:0]           sel_reg = 3'h0;
    logic                 freq_in_range_i = 1'b1;
    logic                 ref_lock_done_i = 1'b0;
    logic                 quiet = 1'b0;
    logic [3:0]           gap = 4'h0;
    logic                 no_light = 1'b0;
    logic [BYTE_BITS-1:0] rx_parallel_out_o;
    logic                 byte_strobe_o, los_o, internal_los_o, data_lock_o, rx_clock_from_ref_o;
    logic                 use_aux_ref_o, main_ref_is_19m44_o, rate_622_o;
    int                   errors = 0;
    int                   n_tests = 0;
    int                   k;
    rx_los_cdr_lock_control rx_los_cdr_lock_control_inst (
        .clk_i(clk_i), .reset_i(reset_i), .rx_serial_in_i(rx_serial_in_i),
        .ext_recovered_clock_i(ext_recovered_clock_i), .external_loss_n_i(external_loss_n_i),
        .recovery_bypass_i(recovery_bypass_i), .internal_los_disable_i(internal_los_disable_i),
        .line_rate_select_i(sel_reg[2]), .ref_freq_select_i(sel_reg[1]), .recovery_ref_select_i(sel_reg[0]),
        .freq_in_range_i(freq_in_range_i), .ref_lock_done_i(ref_lock_done_i),
        .rx_parallel_out_o(rx_parallel_out_o), .byte_strobe_o(byte_strobe_o), .los_o(los_o),
        .internal_los_o(internal_los_o), .data_lock_o(data_lock_o), .rx_clock_from_ref_o(rx_clock_from_ref_o),
        .use_aux_ref_o(use_aux_ref_o), .main_ref_is_19m44_o(main_ref_is_19m44_o), .rate_622_o(rate_622_o)
    );
    optical_line_model optical_line_model_inst (
        .clk_i(clk_i), .quiet_i(quiet), .gap_i(gap), .ext_clock_i(recovery_bypass_i), .no_light_i(no_light),
        .serial_o(rx_serial_in_i), .ext_clock_o(ext_recovered_clock_i), .loss_n_o(external_loss_n_i)
    );
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    // ========================================================================
    // Compare and helper tasks; outputs are read right at the edge, before it lands
    // ========================================================================
    task chk1(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask
    task chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Bytes are not framed, so any rotation of the line pattern is a good byte
    function automatic logic is_rot(input logic [7:0] v);
        logic r;
        r = 1'b0;
        for (int s = 0; s < 8; s++) if (v === ((8'hA5 << s) | (8'hA5 >> (8 - s)))) r = 1'b1;
        return r;
    endfunction
    task wait_strobe(input int n);
        for (k = 0; k < n && byte_strobe_o !== 1'b1; k++) @(posedge clk_i);
    endtask
    task wait_lock(input logic v);
        for (k = 0; k < 40 && data_lock_o !== v; k++) @(posedge clk_i);
        chk1("data lock", v, data_lock_o);
    endtask
    task complete_run;
        $display("errors %0d tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ========================================================================
    // Scenarios
    // ========================================================================
    task t_selects;
        for (int i = 0; i < 8; i++) begin
            sel_reg <= 3'(i);
            repeat (8) @(posedge clk_i);
            chk1("rate", sel_reg[2], rate_622_o);
            chk1("aux ref", sel_reg[0], use_aux_ref_o);
            chk1("main 19m44", sel_reg[1] & ~sel_reg[0], main_ref_is_19m44_o);
        end
    endtask
    task t_lock;
        repeat (40) @(posedge clk_i);
        chk1("early lock", 1'b0, data_lock_o);
        chk1("ref clock", 1'b1, rx_clock_from_ref_o);
        ref_lock_done_i <= 1'b1;
        wait_lock(1'b1);
        wait_strobe(20);
        chk1("byte", 1'b1, is_rot(rx_parallel_out_o));
        chk1("ref clock", 1'b0, rx_clock_from_ref_o);
        freq_in_range_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk1("range lock", 1'b0, data_lock_o);
        chk1("ref clock", 1'b1, rx_clock_from_ref_o);
        freq_in_range_i <= 1'b1;
        wait_lock(1'b1);
    endtask
    task t_internal_los;
        quiet <= 1'b1;
        repeat (125) @(posedge clk_i);
        chk1("early los", 1'b0, internal_los_o);
        repeat (15) @(posedge clk_i);
        chk1("internal los", 1'b1, internal_los_o);
        chk1("los", 1'b1, los_o);
        wait_lock(1'b0);
        wait_strobe(20);
        chk8("muted", MUTE_BYTE, rx_parallel_out_o);
        quiet <= 1'b0;
        gap <= 4'h9;
        repeat (300) @(posedge clk_i);
        chk1("sparse los", 1'b1, internal_los_o);
        gap <= 4'h8;
        for (k = 0; k < 200 && internal_los_o !== 1'b0; k++) @(posedge clk_i);
        chk1("cleared los", 1'b0, internal_los_o);
        gap <= 4'h0;
        wait_lock(1'b1);
    endtask
    task t_disable;
        internal_los_disable_i <= 1'b1;
        quiet <= 1'b1;
        repeat (200) @(posedge clk_i);
        chk1("disabled los", 1'b0, internal_los_o);
        chk1("los", 1'b0, los_o);
        // Line moves again before the detector is re-armed, so the quiet run
        // seen while disabled is not declared afterwards
        quiet <= 1'b0;
        repeat (20) @(posedge clk_i);
        internal_los_disable_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk1("rearmed los", 1'b0, internal_los_o);
    endtask
    task t_external;
        no_light <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk1("ext los", 1'b1, los_o);
        wait_lock(1'b0);
        wait_strobe(20);
        chk8("muted", MUTE_BYTE, rx_parallel_out_o);
        no_light <= 1'b0;
        wait_lock(1'b1);
    endtask
    task t_bypass;
        recovery_bypass_i <= 1'b1;
        repeat (100) @(posedge clk_i);
        wait_strobe(200);
        @(posedge clk_i);
        for (k = 1; k < 200 && byte_strobe_o !== 1'b1; k++) @(posedge clk_i);
        chk8("strobe gap", 8'h40, 8'(k));
        chk1("byte", 1'b1, is_rot(rx_parallel_out_o));
        recovery_bypass_i <= 1'b0;
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        chk1("reset ref clock", 1'b1, rx_clock_from_ref_o);
        chk8("reset byte", MUTE_BYTE, rx_parallel_out_o);
        reset_i <= 1'b0;
        t_selects;
        t_lock;
        t_internal_los;
        t_disable;
        t_external;
        t_bypass;
        complete_run;
    end
    // Whole run is near 1200 cycles; this bound only trips on a hang
    initial begin
        repeat (40000) @(posedge clk_i);
        errors++;
        complete_run;
    end
endmodule // testbench
